// >>> gwopt_pkg.sv
// Package: register layout, bit positions and sizes of the gateway option block
package gwopt_pkg;
   // Option byte register and its bit positions
   localparam logic [3:0] GWOPT_OPT_OFFSET    = 4'h4;
   localparam logic [7:0] GWOPT_OPT_RESET     = 8'h00;
   localparam int         GWOPT_BIT_SWAP      = 0;
   localparam int         GWOPT_BIT_MODDIAG   = 1;
   localparam int         GWOPT_BIT_SUPDIAG   = 2;
   localparam int         GWOPT_BIT_FORCE     = 4;
   localparam int         GWOPT_BIT_DYNCFG    = 6;
   localparam logic [7:0] GWOPT_OPT_USED_MASK = 8'h57;
   // Process data path and diagnostic code width
   localparam int         GWOPT_DATA_W        = 16;
   localparam int         GWOPT_FIFO_DEPTH    = 32;
   localparam int         GWOPT_DIAG_W        = 8;
   // Link state encoding
   typedef enum logic [2:0] {
      GWOPT_RUN     = 3'b001,
      GWOPT_HALTED  = 3'b010,
      GWOPT_PENDCFG = 3'b100
   } gwopt_link_t;
endpackage : gwopt_pkg

// >>> gwopt_fifo.sv
// Module: parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ps
module gwopt_fifo
   import gwopt_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             clkEn,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0]   count;
   } gwopt_fifo_st_t;
   gwopt_fifo_st_t st_q, st_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   // Handshake terms, full and empty
   assign inReady  = (st_q.count != (AW+1)'(DEPTH));
   assign outValid = (st_q.count != '0);
   assign outData  = mem[st_q.rdPtr];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // Pointer and count update
   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.wrPtr = st_q.wrPtr + AW'(1);
      end
      if (pop) begin
         st_d.rdPtr = st_q.rdPtr + AW'(1);
      end
      st_d.count = st_q.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   // State register and storage
   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= '0;
      end else if (clkEn) begin
         st_q <= st_d;
         if (push) begin
            mem[st_q.wrPtr] <= inData;
         end
      end
   end

   fifo_bound_a: assert property (@(posedge clk) disable iff (reset)
      st_q.count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : gwopt_fifo

// >>> gwopt_swap.sv
// Module: byte order stage for 16-bit process data words
`timescale 1ns/1ps
module gwopt_swap
   import gwopt_pkg::*;
(
   input  wire logic                    swapEn,
   input  wire logic [GWOPT_DATA_W-1:0] wordIn,
   output logic      [GWOPT_DATA_W-1:0] wordOut
);
   // Reverse byte lanes when swapping
   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_lane
         assign wordOut[8*i +: 8] = swapEn ? wordIn[8*(1-i) +: 8] : wordIn[8*i +: 8]; // RULE1 RULE2
      end
   endgenerate
endmodule : gwopt_swap

// >>> gwopt_gateway.sv
// Module: gateway option byte latch and its effect on data, diagnostics and config
//
// Overview of operation
// RULE1: Option bit 0 clear: process words pass low byte first, unchanged.
// RULE2: Option bit 0 set: high and low bytes of each 16-bit word swap.
// RULE3: Option bit 1 clear: module diagnostics forwarded to master as extended diagnostics.
// RULE4: Option bit 1 set: module diagnostics dropped, no station diagnostic raised.
// RULE5: Bit 2 clear monitors gateway and feed supplies; gateway only if module diags off.
// RULE6: Option bit 2 set: no supply over or under voltage is reported.
// RULE7: Option bit 4 clear: commissioning tool force request accepted.
// RULE8: Bit 4 set and master parameterized: tool force request rejected.
// RULE9: Bit 6 clear: configuration changes stored, applied only after power-on reset.
// RULE10: Static configuration keeps data exchange running despite sequence error.
// RULE11: Bit 6 set: changed configuration taken over immediately.
// RULE12: Dynamic configuration halts data exchange and bus on sequence error.
// RULE13: No halt when start-up-despite-mismatch option bit is enabled.
// RULE14: Bits 3, 5 and 7 reserved; written zero by master, ignored here.
// RULE15: Whole byte latched when parameterization message accepted; applied afterwards.
`timescale 1ns/1ps
module gwopt_gateway
   import gwopt_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire logic                    clkEn,
   input  wire logic                    powerOnReset,
   // Parameterization message from the master
   input  wire logic                    prmValid,
   input  wire logic [3:0]              prmAddr,
   input  wire logic [7:0]              prmData,
   input  wire logic                    startupMismatchEn,
   output logic      [7:0]              optReadData,
   // Process data from module bus to master
   input  wire logic [GWOPT_DATA_W-1:0] pdInData,
   input  wire logic                    pdInValid,
   output logic                         pdInReady,
   output logic      [GWOPT_DATA_W-1:0] pdOutData,
   output logic                         pdOutValid,
   input  wire logic                    pdOutReady,
   // Module diagnostics
   input  wire logic                    modDiagValid,
   input  wire logic [GWOPT_DIAG_W-1:0] modDiagCode,
   output logic                         extDiagValid,
   output logic      [GWOPT_DIAG_W-1:0] extDiagCode,
   // Supply monitoring
   input  wire logic                    gwSupplyFault,
   input  wire logic                    feedSupplyFault,
   output logic                         supplyAlarm,
   // Force mode from commissioning tool
   input  wire logic                    forceReq,
   output logic                         forceGrant,
   output logic                         forceReject,
   // Station configuration
   input  wire logic                    cfgChange,
   input  wire logic                    seqError,
   output logic                         cfgApply,
   output logic                         busHalted
);
   typedef struct packed {
      logic [7:0]  opt;
      logic        prmDone;
      gwopt_link_t link;
      logic [1:0]  gwSync;
      logic [1:0]  feedSync;
      logic        extDiagValid;
      logic [GWOPT_DIAG_W-1:0] extDiagCode;
      logic        supplyAlarm;
      logic        forceGrant;
      logic        forceReject;
      logic        cfgApply;
      logic        busHalted;
      logic [7:0]  optRead;
   } gwopt_st_t;
   gwopt_st_t st_q, st_d;

   logic                    swapEn;
   logic                    moddiagOff;
   logic                    supdiagOff;
   logic                    forceBlock;
   logic                    dynCfg;
   logic [GWOPT_DATA_W-1:0] swapped;
   logic                    fifoInValid;
   logic                    fifoInReady;
   logic                    fifoOutValid;
   logic                    fifoOutReady;
   logic                    prmHit;

   // Option field decode
   function automatic logic optBit(input logic [7:0] opt, input int pos);
      return opt[pos];
   endfunction : optBit

   assign swapEn     = optBit(st_q.opt, GWOPT_BIT_SWAP);
   assign moddiagOff = optBit(st_q.opt, GWOPT_BIT_MODDIAG);
   assign supdiagOff = optBit(st_q.opt, GWOPT_BIT_SUPDIAG);
   assign forceBlock = optBit(st_q.opt, GWOPT_BIT_FORCE);
   assign dynCfg     = optBit(st_q.opt, GWOPT_BIT_DYNCFG);
   assign prmHit     = prmValid && (prmAddr == GWOPT_OPT_OFFSET);

   // Byte order stage ahead of the FIFO
   gwopt_swap u_swap (
      .swapEn  (swapEn),
      .wordIn  (pdInData),
      .wordOut (swapped)
   );

   // Halted link stalls intake and drain
   assign fifoInValid  = pdInValid && (st_q.link != GWOPT_HALTED); // RULE10 RULE12
   assign pdInReady    = fifoInReady && (st_q.link != GWOPT_HALTED);
   assign fifoOutReady = pdOutReady && (st_q.link != GWOPT_HALTED);
   assign pdOutValid   = fifoOutValid && (st_q.link != GWOPT_HALTED);

   gwopt_fifo #(
      .WIDTH (GWOPT_DATA_W),
      .DEPTH (GWOPT_FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .reset    (reset),
      .clkEn    (clkEn),
      .inData   (swapped),
      .inValid  (fifoInValid),
      .inReady  (fifoInReady),
      .outData  (pdOutData),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady)
   );

   // Next-state logic
   always_comb begin
      st_d = st_q;
      st_d.cfgApply     = 1'b0;
      st_d.forceGrant   = 1'b0;
      st_d.forceReject  = 1'b0;
      st_d.extDiagValid = 1'b0;
      st_d.gwSync       = {st_q.gwSync[0], gwSupplyFault};
      st_d.feedSync     = {st_q.feedSync[0], feedSupplyFault};
      // Latch the whole byte, reserved bits dropped
      if (prmHit) begin
         st_d.opt     = prmData & GWOPT_OPT_USED_MASK; // RULE15 RULE14
         st_d.prmDone = 1'b1;
      end
      st_d.optRead = st_d.opt;
      // Module diagnostics forwarding
      if (modDiagValid && !moddiagOff) begin
         st_d.extDiagValid = 1'b1; // RULE3
         st_d.extDiagCode  = modDiagCode;
      end // RULE4
      // Supply monitoring
      if (supdiagOff) begin
         st_d.supplyAlarm = 1'b0; // RULE6
      end else if (moddiagOff) begin
         st_d.supplyAlarm = st_q.gwSync[1]; // RULE5
      end else begin
         st_d.supplyAlarm = st_q.gwSync[1] | st_q.feedSync[1]; // RULE5
      end
      // Force request arbitration
      if (forceReq) begin
         if (forceBlock && st_q.prmDone) begin
            st_d.forceReject = 1'b1; // RULE8
         end else begin
            st_d.forceGrant = 1'b1; // RULE7
         end
      end
      // Configuration takeover and sequence error
      case (st_q.link)
         GWOPT_RUN: begin
            if (cfgChange && dynCfg) begin
               st_d.cfgApply = 1'b1; // RULE11
            end else if (cfgChange) begin
               st_d.link = GWOPT_PENDCFG; // RULE9
            end
            if (seqError && dynCfg && !startupMismatchEn) begin
               st_d.link = GWOPT_HALTED; // RULE12 RULE13
            end
         end
         GWOPT_PENDCFG: begin
            if (powerOnReset) begin
               st_d.cfgApply = 1'b1; // RULE9
               st_d.link     = GWOPT_RUN;
            end else if (seqError && dynCfg && !startupMismatchEn) begin
               st_d.link = GWOPT_HALTED; // RULE12
            end
         end
         GWOPT_HALTED: begin
            if (powerOnReset) begin
               st_d.link = GWOPT_RUN;
            end
         end
         default: begin
            st_d.link = GWOPT_RUN;
         end
      endcase
      st_d.busHalted = (st_d.link == GWOPT_HALTED);
   end

   // State register
   always_ff @(posedge clk) begin
      if (reset) begin
         st_q      <= '0;
         st_q.opt  <= GWOPT_OPT_RESET;
         st_q.link <= GWOPT_RUN;
      end else if (clkEn) begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flip-flops
   assign optReadData  = st_q.optRead;
   assign extDiagValid = st_q.extDiagValid;
   assign extDiagCode  = st_q.extDiagCode;
   assign supplyAlarm  = st_q.supplyAlarm;
   assign forceGrant   = st_q.forceGrant;
   assign forceReject  = st_q.forceReject;
   assign cfgApply     = st_q.cfgApply;
   assign busHalted    = st_q.busHalted;

   // Checks
   // Parameter byte taken while the clock runs
   sequence prm_write_s;
      prmHit && clkEn;
   endsequence

   // Configuration change in run state under static takeover
   sequence cfg_store_s;
      clkEn && st_q.link == GWOPT_RUN && cfgChange && !dynCfg;
   endsequence

   // Power-on event while a stored configuration waits
   sequence cfg_power_s;
      clkEn && st_q.link == GWOPT_PENDCFG && powerOnReset;
   endsequence

   // Sequence error in run state that must stop the link
   sequence seq_stop_s;
      clkEn && st_q.link == GWOPT_RUN && seqError && dynCfg && !startupMismatchEn;
   endsequence

   // Sequence error that must leave the link running
   sequence seq_keep_s;
      clkEn && st_q.link != GWOPT_HALTED && seqError && (!dynCfg || startupMismatchEn);
   endsequence

   // Written byte lands one cycle later
   prm_latch_a: assert property (@(posedge clk) disable iff (reset) // RULE15
      prm_write_s |=> st_q.opt == ($past(prmData) & 8'h57))
      else $error("option byte not latched");

   // Reserved bits never stored
   reserved_zero_a: assert property (@(posedge clk) disable iff (reset) // RULE14
      (st_q.opt & 8'ha8) == 8'h00)
      else $error("reserved bit stored");

   // Byte lanes ahead of the FIFO
   swap_lane_a: assert property (@(posedge clk) disable iff (reset) // RULE1 RULE2
      swapped == (swapEn ? {pdInData[7:0], pdInData[15:8]} : pdInData))
      else $error("byte order wrong");

   // Enabled diagnostics raise a pulse
   diag_fwd_a: assert property (@(posedge clk) disable iff (reset) // RULE3
      clkEn && modDiagValid && !moddiagOff |=> extDiagValid)
      else $error("diag not forwarded");

   // Forwarded code matches the event
   diag_code_a: assert property (@(posedge clk) disable iff (reset) // RULE3
      clkEn && modDiagValid && !moddiagOff |=> extDiagCode == $past(modDiagCode))
      else $error("diag code lost");

   // Disabled diagnostics stay silent
   diag_drop_a: assert property (@(posedge clk) disable iff (reset) // RULE4
      clkEn && modDiagValid && moddiagOff |=> !extDiagValid)
      else $error("diag not suppressed");

   // No alarm with supply monitoring off
   supply_off_a: assert property (@(posedge clk) disable iff (reset) // RULE6
      clkEn && supdiagOff |=> !supplyAlarm)
      else $error("supply alarm while disabled");

   // Gateway supply only with module diagnostics off
   supply_gw_a: assert property (@(posedge clk) disable iff (reset) // RULE5
      clkEn && !supdiagOff && moddiagOff |=> supplyAlarm == $past(st_q.gwSync[1]))
      else $error("gateway supply alarm wrong");

   // Both supplies watched otherwise
   supply_both_a: assert property (@(posedge clk) disable iff (reset) // RULE5
      clkEn && !supdiagOff && !moddiagOff
      |=> supplyAlarm == ($past(st_q.gwSync[1]) || $past(st_q.feedSync[1])))
      else $error("feed supply alarm wrong");

   // Blocked tool request refused
   force_block_a: assert property (@(posedge clk) disable iff (reset) // RULE8
      clkEn && forceReq && forceBlock && st_q.prmDone |=> forceReject && !forceGrant)
      else $error("force not rejected");

   // Released tool request granted
   force_allow_a: assert property (@(posedge clk) disable iff (reset) // RULE7
      clkEn && forceReq && !forceBlock |=> forceGrant)
      else $error("force not granted");

   // Dynamic takeover stops on sequence error
   seq_halt_a: assert property (@(posedge clk) disable iff (reset) // RULE12 RULE13
      seq_stop_s |=> busHalted)
      else $error("no halt on sequence error");

   // Static or masked sequence error keeps running
   seq_nohalt_a: assert property (@(posedge clk) disable iff (reset) // RULE10 RULE13
      seq_keep_s |=> !busHalted)
      else $error("exchange stopped");

   // No data moves while halted
   halt_stall_a: assert property (@(posedge clk) disable iff (reset) // RULE12
      st_q.link == GWOPT_HALTED |-> !pdOutValid && !pdInReady)
      else $error("data moved while halted");

   // Halt holds until power-on
   halt_hold_a: assert property (@(posedge clk) disable iff (reset) // RULE12
      clkEn && st_q.link == GWOPT_HALTED && !powerOnReset |=> busHalted)
      else $error("halt left early");

   // Dynamic change taken over at once
   dyn_apply_a: assert property (@(posedge clk) disable iff (reset) // RULE11
      clkEn && st_q.link == GWOPT_RUN && cfgChange && dynCfg |=> cfgApply)
      else $error("dynamic config not applied");

   // Static change not applied early
   static_hold_a: assert property (@(posedge clk) disable iff (reset) // RULE9
      cfg_store_s |=> !cfgApply)
      else $error("static config applied early");

   // Static change kept pending
   pend_store_a: assert property (@(posedge clk) disable iff (reset) // RULE9
      cfg_store_s |=> st_q.link == GWOPT_PENDCFG)
      else $error("static config not stored");

   // Stored change applied on power-on
   static_apply_a: assert property (@(posedge clk) disable iff (reset) // RULE9
      cfg_power_s |=> cfgApply && !busHalted)
      else $error("stored config not applied");

   // Disabled clock freezes all state
   freeze_hold_a: assert property (@(posedge clk) disable iff (reset)
      !clkEn |=> $stable(st_q))
      else $error("state moved while frozen");
endmodule : gwopt_gateway

// >>> gwopt_master_model.sv
// Fieldbus master model that writes parameter bytes
`timescale 1ns/1ps
module gwopt_master_model (
   input  wire logic       clk,
   output logic            prmValid,
   output logic      [3:0] prmAddr,
   output logic      [7:0] prmData
);
   // Idle strobe low at time zero
   initial begin
      prmValid = 1'b0;
      prmAddr  = 4'h0;
      prmData  = 8'h00;
   end
   // One byte per call; reserved bits zero unless told otherwise
   task send(input logic [3:0] a, input logic [7:0] d, input logic dirty);
      @(negedge clk);
      prmValid = 1'b1;
      prmAddr  = a;
      prmData  = dirty ? d : (d & 8'h57);
      @(negedge clk);
      prmValid = 1'b0;
      prmAddr  = ~a;
      prmData  = ~prmData; // Stale byte not left on the lines
   endtask : send
endmodule : gwopt_master_model

// >>> gwopt_gateway_tb.sv
// Self-checking testbench of the gateway option block
`timescale 1ns/1ps
module gwopt_gateway_tb;
   logic        clk = 1'b0, reset = 1'b1, clkEn = 1'b1, powerOnReset = 1'b0;
   logic        startupMismatchEn = 1'b0, pdInValid = 1'b0, pdOutReady = 1'b0;
   logic        modDiagValid = 1'b0, gwSupplyFault = 1'b0, feedSupplyFault = 1'b0;
   logic        forceReq = 1'b0, cfgChange = 1'b0, seqError = 1'b0, seen;
   logic [15:0] pdInData = 16'h0000, pdOutData;
   logic [7:0]  modDiagCode = 8'h00, prmData, optReadData, extDiagCode, opt;
   logic [3:0]  prmAddr;
   logic        prmValid, pdInReady, pdOutValid, extDiagValid, supplyAlarm;
   logic        forceGrant, forceReject, cfgApply, busHalted;
   logic [31:0] seed = 32'h1d466d0c;
   logic [15:0] q[$];
   int          badCount = 0, nChecks = 0, cycles = 0, n;

   // Design and master model
   gwopt_gateway gwopt_gateway_i (.clk, .reset, .clkEn, .powerOnReset, .prmValid, .prmAddr,
      .prmData, .startupMismatchEn, .optReadData, .pdInData, .pdInValid, .pdInReady,
      .pdOutData, .pdOutValid, .pdOutReady, .modDiagValid, .modDiagCode, .extDiagValid,
      .extDiagCode, .gwSupplyFault, .feedSupplyFault, .supplyAlarm, .forceReq, .forceGrant,
      .forceReject, .cfgChange, .seqError, .cfgApply, .busHalted);
   gwopt_master_model gwopt_master_model_i (.clk, .prmValid, .prmAddr, .prmData);

   // 50 ns clock
   always #25 clk = ~clk;

   // Cycle ceiling against hangs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         badCount++;
         conclude();
      end
   end

   // Pseudo-random source
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // Compare and count
   task check(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) begin
         badCount++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Verdict and end of run
   task conclude();
      if (badCount == 0 && nChecks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude

   // Option write with model update
   task wr(input logic [7:0] d);
      gwopt_master_model_i.send(4'h4, d, 1'b0);
      opt = d & 8'h57;
   endtask : wr

   // Power-on pulse, notes any takeover
   task por();
      powerOnReset = 1'b1;
      @(negedge clk);
      powerOnReset = 1'b0;
      seen = cfgApply;
      @(negedge clk);
      seen = seen | cfgApply;
   endtask : por

   // Main sequence
   initial begin
      repeat (4) @(negedge clk);
      reset = 1'b0;
      check({optReadData, pdOutValid, pdInReady}, 10'h001);
      // Random option bytes, reserved bits set, and a foreign address
      repeat (8) begin
         seed = lfsr(seed);
         gwopt_master_model_i.send(4'h4, seed[7:0], 1'b1);
         opt = seed[7:0] & 8'h57;
         check(optReadData, opt);
         gwopt_master_model_i.send(4'h5, ~seed[7:0], 1'b1);
         check(optReadData, opt);
      end
      // Fill in both byte orders until refused
      wr(8'h00);
      n = 0;
      while (pdInReady === 1'b1 && n < 40) begin
         if (n == 16) begin
            pdInValid = 1'b0;
            wr(8'h01);
         end
         seed = lfsr(seed);
         pdInData = seed[15:0];
         pdInValid = 1'b1;
         q.push_back(opt[0] ? {seed[7:0], seed[15:8]} : seed[15:0]);
         @(negedge clk);
         n++;
      end
      pdInValid = 1'b0;
      check(n, 32);
      // Drain with far-side stalls and frozen cycles
      while (q.size() > 0 && n < 300) begin
         seed = lfsr(seed);
         clkEn = seed[0] | seed[1];
         pdOutReady = seed[2] | seed[3];
         check(pdOutValid, 1'b1);
         check(pdOutData, q[0]);
         if (clkEn && pdOutReady) void'(q.pop_front());
         @(negedge clk);
         n++;
      end
      clkEn = 1'b1;
      check(pdOutValid, 1'b0);
      // Diagnostics and force requests under both settings
      for (int b = 0; b < 2; b++) begin
         wr({3'h0, b[0], 2'h0, b[0], 1'b0});
         seed = lfsr(seed);
         modDiagCode = seed[7:0];
         modDiagValid = 1'b1;
         forceReq = 1'b1;
         @(negedge clk);
         modDiagValid = 1'b0;
         forceReq = 1'b0;
         check(extDiagValid, !b[0]);
         if (b == 0) check(extDiagCode, seed[7:0]);
         check({forceGrant, forceReject}, {!b[0], b[0]});
      end
      // Supply monitoring over all setting and fault combinations
      for (int i = 0; i < 16; i++) begin
         wr({5'h0, i[0], i[1], 1'b0});
         gwSupplyFault = i[2];
         feedSupplyFault = i[3];
         repeat (5) @(negedge clk);
         check(supplyAlarm, !i[0] && (i[2] || (i[3] && !i[1])));
      end
      gwSupplyFault = 1'b0;
      feedSupplyFault = 1'b0;
      // Dynamic takeover is immediate
      wr(8'h40);
      cfgChange = 1'b1;
      @(negedge clk);
      cfgChange = 1'b0;
      check(cfgApply, 1'b1);
      // Static takeover waits for power-on
      wr(8'h00);
      cfgChange = 1'b1;
      @(negedge clk);
      cfgChange = 1'b0;
      repeat (3) @(negedge clk);
      check(cfgApply, 1'b0);
      por();
      check(seen, 1'b1);
      // Sequence error: static, masked dynamic, then halting dynamic
      seqError = 1'b1;
      repeat (2) @(negedge clk);
      check({busHalted, pdInReady}, 2'b01);
      startupMismatchEn = 1'b1;
      wr(8'h40);
      repeat (2) @(negedge clk);
      check({busHalted, pdInReady}, 2'b01);
      startupMismatchEn = 1'b0;
      pdOutReady = 1'b0;
      pdInValid = 1'b1;
      q.push_back(opt[0] ? {pdInData[7:0], pdInData[15:8]} : pdInData);
      @(negedge clk);
      pdInValid = 1'b0;
      check({busHalted, pdInReady, pdOutValid}, 3'b100);
      seqError = 1'b0;
      por();
      check({busHalted, pdOutValid}, 2'b01);
      check(pdOutData, q[0]);
      pdOutReady = 1'b1;
      @(negedge clk);
      check({busHalted, pdOutValid}, 2'b00);
      conclude();
   end
endmodule : gwopt_gateway_tb
